// ---- pdc_pin_model.sv ----
`default_nettype none
module pdc_pin_model (
   input wire logic               ref_clk,
   input wire pdc_pkg::pdc_pins_s pins_o,
   input wire logic [14:0]        ext,
   input wire logic               ext_en,
   output logic [14:0]            pin_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // An undriven pin with its pull-up off and ext_en low has no level, so it wanders each cycle.
   logic [14:0] flt = 15'h0;
   always @(posedge ref_clk) flt <= ~flt;
   assign pin_in = pins_o.oe_n & (ext_en ? ext : pins_o.pullup_en | flt)
                 | ~pins_o.oe_n & pins_o.drive;
endmodule
`default_nettype wire

// ---- pdc_pkg.sv ----
`default_nettype none
package pdc_pkg;
   localparam int unsigned PORT0_W  = 8;
   localparam int unsigned PORT1_W  = 7;
   localparam int unsigned PIN_W    = PORT0_W + PORT1_W;
   localparam int unsigned ADDR_W   = 8;
   localparam int unsigned DATA_W   = 32;

   // Register indices; the byte address on the bus is four times the index.
   localparam logic [ADDR_W-1:0] IDX_PORT0_DIR = 8'h08;
   localparam logic [ADDR_W-1:0] IDX_PORT1_DIR = 8'h09;
   localparam logic [ADDR_W-1:0] IDX_PORT0_OUT = 8'h0A;
   localparam logic [ADDR_W-1:0] IDX_PORT1_OUT = 8'h0B;
   localparam logic [ADDR_W-1:0] IDX_PIN_LEVEL = 8'h0C;
   localparam int unsigned       IDX_SHIFT     = 2;

   localparam logic [PORT0_W-1:0] PORT0_DIR_RST = 8'h00;
   localparam logic [PORT1_W-1:0] PORT1_DIR_RST = 7'h00;
   localparam logic [PORT0_W-1:0] PORT0_OUT_RST = 8'h00;
   localparam logic [PORT1_W-1:0] PORT1_OUT_RST = 7'h00;

   typedef struct packed {
      logic [PIN_W-1:0] drive;     // Level driven while enabled.
      logic [PIN_W-1:0] oe_n;      // Low while the pin is driven.
      logic [PIN_W-1:0] pullup_en; // Weak pull-up switched on.
   } pdc_pins_s;

   localparam pdc_pins_s PINS_RST = '{drive: 15'h0000, oe_n: 15'h7FFF, pullup_en: 15'h0000};
endpackage
`default_nettype wire

// ---- pdc_port_dir.sv ----
// Added by the designer: the Wishbone register port.
`default_nettype none
module pdc_port_dir (
   input  wire logic                        ref_clk,   // System clock, 10 MHz.
   input  wire logic                        nrst,      // Asynchronous reset, active low.
   input  wire logic                        wb_cyc_i,  // Wishbone cycle.
   input  wire logic                        wb_stb_i,  // Wishbone strobe.
   input  wire logic                        wb_we_i,   // Wishbone write enable.
   input  wire logic [pdc_pkg::ADDR_W-1:0]  wb_adr_i,  // Wishbone byte address.
   input  wire logic [3:0]                  wb_sel_i,  // Wishbone byte selects.
   input  wire logic [pdc_pkg::DATA_W-1:0]  wb_dat_i,  // Wishbone write data.
   output var  logic [pdc_pkg::DATA_W-1:0]  wb_dat_o,  // Wishbone read data.
   output var  logic                        wb_ack_o,  // Wishbone acknowledge.
   input  wire logic [pdc_pkg::PIN_W-1:0]   pin_in,    // Pin levels, port 1 above port 0.
   output var  pdc_pkg::pdc_pins_s          pins_o     // Pin drive, enable and pull-up.
);

   ////////////////////////////////////////////////////////////////////////////////
   // Register file.

   logic [pdc_pkg::PORT0_W-1:0] p0_dir_reg;
   logic [pdc_pkg::PORT0_W-1:0] p0_dir_next;
   logic [pdc_pkg::PORT1_W-1:0] p1_dir_reg;
   logic [pdc_pkg::PORT1_W-1:0] p1_dir_next;
   logic [pdc_pkg::PORT0_W-1:0] p0_out_reg;
   logic [pdc_pkg::PORT0_W-1:0] p0_out_next;
   logic [pdc_pkg::PORT1_W-1:0] p1_out_reg;
   logic [pdc_pkg::PORT1_W-1:0] p1_out_next;
   logic [pdc_pkg::PIN_W-1:0]   level_reg;
   logic [pdc_pkg::PIN_W-1:0]   level_next;
   logic [pdc_pkg::ADDR_W-1:0]  reg_idx;
   logic                        access;
   logic                        wr_lane0;

   assign reg_idx  = wb_adr_i >> pdc_pkg::IDX_SHIFT;
   assign access   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   // Only byte lane 0 carries write data (pin levels read back on lanes 0 and 1); a write without it changes nothing.
   assign wr_lane0 = access & wb_we_i & wb_sel_i[0];

   always_comb begin
      p0_dir_next = p0_dir_reg;
      p1_dir_next = p1_dir_reg;
      p0_out_next = p0_out_reg;
      p1_out_next = p1_out_reg;
      level_next  = pin_in;
      if (wr_lane0) begin
         case (reg_idx)
            pdc_pkg::IDX_PORT0_DIR: p0_dir_next = wb_dat_i[pdc_pkg::PORT0_W-1:0];
            pdc_pkg::IDX_PORT1_DIR: p1_dir_next = wb_dat_i[pdc_pkg::PORT1_W-1:0];
            pdc_pkg::IDX_PORT0_OUT: p0_out_next = wb_dat_i[pdc_pkg::PORT0_W-1:0];
            pdc_pkg::IDX_PORT1_OUT: p1_out_next = wb_dat_i[pdc_pkg::PORT1_W-1:0];
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         p0_dir_reg <= pdc_pkg::PORT0_DIR_RST;
         p1_dir_reg <= pdc_pkg::PORT1_DIR_RST;
         p0_out_reg <= pdc_pkg::PORT0_OUT_RST;
         p1_out_reg <= pdc_pkg::PORT1_OUT_RST;
         level_reg  <= '0;
      end else begin
         p0_dir_reg <= p0_dir_next;
         p1_dir_reg <= p1_dir_next;
         p0_out_reg <= p0_out_next;
         p1_out_reg <= p1_out_next;
         level_reg  <= level_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Bus answer: every access, mapped or not, is acknowledged one cycle later.

   logic [pdc_pkg::DATA_W-1:0] rd_next;
   logic                       ack_next;

   always_comb begin
      ack_next = access;
      rd_next  = '0;
      if (access && !wb_we_i) begin
         case (reg_idx)
            pdc_pkg::IDX_PORT0_DIR: rd_next = {24'h00_0000, p0_dir_reg};
            // The reserved top bit is never stored, so it always reads zero.
            pdc_pkg::IDX_PORT1_DIR: rd_next = {25'h000_0000, p1_dir_reg};
            pdc_pkg::IDX_PORT0_OUT: rd_next = {24'h00_0000, p0_out_reg};
            pdc_pkg::IDX_PORT1_OUT: rd_next = {25'h000_0000, p1_out_reg};
            pdc_pkg::IDX_PIN_LEVEL: rd_next = {17'h0_0000, level_reg};
            default:                rd_next = '0;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= ack_next;
         wb_dat_o <= rd_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pin control, one slice per pin; registered so the pads see no decode glitches.

   logic [pdc_pkg::PIN_W-1:0] dir_all;
   logic [pdc_pkg::PIN_W-1:0] out_all;
   pdc_pkg::pdc_pins_s        pins_next;

   assign dir_all = {p1_dir_reg, p0_dir_reg};
   assign out_all = {p1_out_reg, p0_out_reg};

   for (genvar i = 0; i < pdc_pkg::PIN_W; i++) begin : g_pin
      // Each slice reads only its own direction bit.
      assign pins_next.drive[i]     = dir_all[i] & out_all[i];
      assign pins_next.oe_n[i]      = ~dir_all[i];
      assign pins_next.pullup_en[i] = ~dir_all[i] & out_all[i];
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pins_o <= pdc_pkg::PINS_RST;
      end else begin
         pins_o <= pins_next;
      end
   end

endmodule
`default_nettype wire

// ---- pdc_port_dir_sva.sv ----
`default_nettype none
module pdc_port_dir_sva (
   input wire logic               ref_clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
   input wire logic [7:0]         wb_adr_i,
   input wire logic [3:0]         wb_sel_i,
   input wire logic [31:0]        wb_dat_i, wb_dat_o,
   input wire pdc_pkg::pdc_pins_s pins_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic       wr;
   logic [5:0] ix;
   assign ix = wb_adr_i[7:2];
   assign wr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   a_pullup_input: assert property ((pins_o.pullup_en & ~pins_o.oe_n) == 15'h0)
      else $error("pullup on output");
   a_drive_enabled: assert property ((pins_o.drive & pins_o.oe_n) == 15'h0)
      else $error("drive on input");
   a_reset_input: assert property ($rose(nrst) |-> pins_o.oe_n == 15'h7FFF)
      else $error("pin not input after reset");
   a_dir0_apply: assert property (wr && ix == 6'h08 |-> ##2
      pins_o.oe_n[7:0] == ~$past(wb_dat_i[7:0], 2)) else $error("port0 enable");
   a_dir1_apply: assert property (wr && ix == 6'h09 |-> ##2
      pins_o.oe_n[14:8] == ~$past(wb_dat_i[6:0], 2)) else $error("port1 enable");
   a_out0_pullup: assert property (wr && ix == 6'h0A |-> ##2
      pins_o.pullup_en[7:0] == (pins_o.oe_n[7:0] & $past(wb_dat_i[7:0], 2)))
      else $error("port0 pullup");
   a_out1_drive: assert property (wr && ix == 6'h0B |-> ##2
      pins_o.drive[14:8] == (~pins_o.oe_n[14:8] & $past(wb_dat_i[6:0], 2)))
      else $error("port1 drive");
   a_dir1_read: assert property (wb_ack_o && !wb_we_i && ix == 6'h09 |->
      wb_dat_o == {25'h0, ~pins_o.oe_n[14:8]}) else $error("port1 readback");
   a_dir_independent: assert property (wr && ix == 6'h08 |-> ##2
      pins_o.oe_n[14:8] == $past(pins_o.oe_n[14:8])) else $error("port1 touched");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack one cycle after request");
   cover property (wr && ix == 6'h08);
   cover property (wb_ack_o && ix == 6'h0C);
   cover property ($rose(nrst));
endmodule
`default_nettype wire

// ---- pdc_port_dir_tb.sv ----
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module pdc_port_dir_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 0, nrst = 0, cyc = 0, stb = 0, we = 0, ext_en = 0;
   logic [7:0] adr = 0;
   logic [31:0] dat = 0, q, q0;
   logic [3:0] sel = 4'hF;
   wire logic [31:0] wb_dat_o;
   wire logic wb_ack_o;
   wire logic [14:0] pin_in;
   pdc_pkg::pdc_pins_s pins_o;
   int n_errors = 0, n_compared = 0;
   initial forever #50 ref_clk = ~ref_clk;
   pdc_port_dir i_pdc_port_dir (.ref_clk, .nrst, .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o,
      .wb_ack_o, .pin_in, .pins_o);
   pdc_pin_model i_pdc_pin_model (.ref_clk, .pins_o, .ext(15'h2A5A), .ext_en, .pin_in);
   //////////////////////////////////////////////////////////////////////////
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      dat <= d;
      do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      cyc <= 0;
      stb <= 0;
   endtask
   task automatic end_sim;
      $display("errors=%0d compared=%0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (2000) @(posedge ref_clk);
      n_errors++;
      end_sim();
   end
   initial begin
      repeat (20) @(posedge ref_clk);
      // The second pass follows a reset in mid-run after everything was set.
      for (int r = 0; r < 2; r++) begin
         nrst <= 1;
         wb(0, 8'h20, 0);
         `CHK(q, 32'h0)
         wb(0, 8'h24, 0);
         `CHK(q, 32'h0)
         wb(1, 8'h20, 32'h0000_00A5);
         wb(0, 8'h20, 0);
         `CHK(q, 32'h0000_00A5)
         // A write without byte lane 0 must leave the register as it was.
         sel <= 4'h0;
         wb(1, 8'h20, 32'h0000_005A);
         sel <= 4'hF;
         wb(0, 8'h20, 0);
         `CHK(q, 32'h0000_00A5)
         wb(1, 8'h24, 32'h0000_00FF);
         wb(0, 8'h24, 0);
         `CHK(q, 32'h0000_007F)
         wb(1, 8'h28, 32'h0000_000F);
         wb(1, 8'h2C, 32'h0000_0055);
         wb(0, 8'h30, 0);
         q0 = q;
         wb(0, 8'h30, 0);
         `CHK(q0[14:0] & 15'h7FAF, 15'h550F)
         `CHK(q[14:0] & 15'h7FAF, 15'h550F)
         // Reads come three cycles apart, so the floating pins 6 and 4 differ.
         `CHK((q0[14:0] ^ q[14:0]) & 15'h0050, 15'h0050)
         ext_en <= 1;
         wb(0, 8'h30, 0);
         `CHK(q, 32'h0000_555F)
         wb(0, 8'h3C, 0);
         `CHK(q, 32'h0)
         nrst <= 0;
         ext_en <= 0;
         repeat (2) @(posedge ref_clk);
      end
      end_sim();
   end
endmodule
bind pdc_port_dir pdc_port_dir_sva i_pdc_port_dir_sva (
   .ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .pins_o(pins_o));
`default_nettype wire
